// ==== design/tli_map.svh ====
// Timing counts and field constants for the link integrity block
`ifndef TLI_MAP_SVH
`define TLI_MAP_SVH

`define TLI_CLK_MHZ 125
`define TLI_PULSE_NS 100
`define TLI_PULSE_CYC ((`TLI_PULSE_NS * `TLI_CLK_MHZ) / 1000)
`define TLI_WIN_OPEN_US 6500
`define TLI_WIN_OPEN_CYC (`TLI_WIN_OPEN_US * `TLI_CLK_MHZ)
`define TLI_WIN_CLOSE_US 104000
`define TLI_WIN_CLOSE_CYC (`TLI_WIN_CLOSE_US * `TLI_CLK_MHZ)
`define TLI_LP_PERIOD_US 16000
`define TLI_LP_PERIOD_CYC (`TLI_LP_PERIOD_US * `TLI_CLK_MHZ)
`define TLI_CAL_US 3200
`define TLI_CAL_CYC (`TLI_CAL_US * `TLI_CLK_MHZ)
`define TLI_REV_IDLE_LIMIT 2
`define TLI_REV_LINK_LIMIT 4

`endif

// ==== design/tli_pkg.sv ====
// Types shared by the link integrity block
package tli_pkg;

	typedef enum logic [1:0] {
		TLI_LINK_IDLE,
		TLI_LINK_FAIL,
		TLI_LINK_WAIT
	} tli_link_state_t;

	// Receive-side events, already synchronised
	typedef struct packed {
		logic link_pulse;
		logic pulse_reversed;
		logic frame_end;
		logic idle_reversed;
		logic rx_active;
	} tli_rx_ev_t;

	// Function enables seen by the rest of the device
	typedef struct packed {
		logic tx_enable;
		logic rx_enable;
		logic loopback_enable;
	} tli_func_en_t;

endpackage : tli_pkg

// ==== design/tli_timer.sv ====
// Resettable elapsed-time counter with terminal flags
`timescale 1ns/1ps
`default_nettype none

module tli_timer #(
	parameter int WIDTH = 24,
	parameter logic [WIDTH-1:0] OPEN_CNT = 1,
	parameter logic [WIDTH-1:0] CLOSE_CNT = 2
) (
	input wire logic clock, // System clock
	input wire logic reset, // Sync reset, high
	input wire logic restart, // Begin timing from zero
	output logic past_open, // Open count reached
	output logic past_close // Close count reached
);

	logic [WIDTH-1:0] count_reg;

	initial
	begin
		if (OPEN_CNT == 0 || OPEN_CNT >= CLOSE_CNT)
			$error("tli_timer: open count must be below close count");
	end

	// Saturates so the close flag holds until restart
	always_ff @(posedge clock)
	begin
		if (reset || restart)
			count_reg <= '0;
		else if (count_reg != CLOSE_CNT)
			count_reg <= count_reg + 1'b1;
	end

	always_ff @(posedge clock)
	begin
		if (reset || restart)
			past_open <= 1'b0;
		else if (count_reg >= OPEN_CNT - 1'b1)
			past_open <= 1'b1;
	end

	always_ff @(posedge clock)
	begin
		if (reset || restart)
			past_close <= 1'b0;
		else if (count_reg >= CLOSE_CNT - 1'b1)
			past_close <= 1'b1;
	end

endmodule : tli_timer

`default_nettype wire

// ==== design/tli_pulse_gen.sv ====
// Periodic link pulse generator for the transmit pair
`timescale 1ns/1ps
`default_nettype none

module tli_pulse_gen #(
	parameter int PERIOD_CYC = 2000000,
	parameter int WIDTH_CYC = 12
) (
	input wire logic clock, // System clock
	input wire logic reset, // Sync reset, high
	input wire logic tx_busy, // Transmit traffic present
	input wire logic enable, // Unit powered and calibrated
	output logic pulse_out, // Link pulse level
	output logic pulse_sent // One cycle at pulse start
);

	localparam int CW = $clog2(PERIOD_CYC + 1);
	logic [CW-1:0] period_reg;
	logic [CW-1:0] width_reg;

	initial
	begin
		if (WIDTH_CYC < 1 || WIDTH_CYC >= PERIOD_CYC)
			$error("tli_pulse_gen: bad pulse width or period");
	end

	// Period restarts on traffic, so pulses only fill idle gaps
	always_ff @(posedge clock)
	begin
		if (reset || tx_busy || !enable)
			period_reg <= '0;
		else if (period_reg == CW'(PERIOD_CYC - 1))
			period_reg <= '0;
		else
			period_reg <= period_reg + 1'b1;
	end

	assign pulse_sent = enable && !tx_busy &&
		period_reg == CW'(PERIOD_CYC - 1);

	always_ff @(posedge clock)
	begin
		if (reset || !enable)
			width_reg <= '0;
		else if (pulse_sent)
			width_reg <= CW'(WIDTH_CYC);
		else if (width_reg != '0)
			width_reg <= width_reg - 1'b1;
	end

	always_ff @(posedge clock)
	begin
		if (reset)
			pulse_out <= 1'b0;
		else
			pulse_out <= pulse_sent || width_reg > CW'(1);
	end

endmodule : tli_pulse_gen

`default_nettype wire

// ==== design/tli_link_integrity.sv ====
// Link integrity, polarity, media select and power-down control
`timescale 1ns/1ps
`default_nettype none
`include "tli_map.svh"

// Summary of operation
// - A transmitted link pulse is a high level of about 100 ns.
// - The reception window opens 6.5 ms after last pulse or frame.
// - The reception window closes 104 ms after last pulse or frame.
// - Pulses before the window opens are ignored, except by polarity sensing.
// - Window expiry with no pulse enters link failure.
// - In link failure transmit, loopback and receive are disabled.
// - Pulse or traffic inside the open window restarts the timers.
// - Two in-window pulses spaced 6.5 ms apart mean recovery.
// - A received data packet after failure is also recovery.
// - Recovery moves to wait, with functions still disabled.
// - Wait becomes idle once neither direction carries traffic.
// - Send a link pulse every 16 ms while transmit is quiet.
// - Link pulses continue during jabber and link failure.
// - Polarity sensed from end-of-packet idle pulses, and link pulses.
// - A proper idle pulse keeps the polarity logic normal.
// - Two reversed idle pulses or four reversed link pulses reverse.
// - When reversed, received data is inverted internally.
// - Switch between attachment and twisted pair on cable change.
// - Unselected unit powers down; resume after 3.2 ms calibration.
module tli_link_integrity
	import tli_pkg::*;
#(
	parameter int WIN_OPEN_CYC = `TLI_WIN_OPEN_CYC,
	parameter int WIN_CLOSE_CYC = `TLI_WIN_CLOSE_CYC,
	parameter int LP_PERIOD_CYC = `TLI_LP_PERIOD_CYC,
	parameter int CAL_CYC = `TLI_CAL_CYC,
	parameter int PULSE_CYC = `TLI_PULSE_CYC
) (
	input wire logic clock, // 125 MHz system clock
	input wire logic reset, // Sync reset, high
	input wire tli_pkg::tli_rx_ev_t rx_ev, // Receive events, same clock
	input wire logic rx_data_raw, // Received pair data, same clock
	input wire logic tx_active, // Transmit traffic present
	input wire logic polarity_fix_en, // Polarity correction enabled
	input wire logic link_check_en, // Link integrity enabled
	input wire logic tp_cable_pin, // Pair cable sensed, async pin
	output tli_pkg::tli_func_en_t func_en, // Function enables
	output tli_pkg::tli_link_state_t link_state, // Link state
	output logic rx_data, // Polarity-corrected data
	output logic polarity_reversed, // Polarity is reversed
	output logic tp_selected, // Pair port selected
	output logic tp_power_down, // Pair unit powered down
	output logic tp_ready, // Pair unit calibrated
	output logic link_pulse_out // Transmit link pulse
);

	localparam int CALW = $clog2(CAL_CYC + 1);
	localparam int WW = $clog2(WIN_CLOSE_CYC + 1);

	initial
	begin
		if (WIN_OPEN_CYC < 1 || WIN_OPEN_CYC >= WIN_CLOSE_CYC)
			$error("tli_link_integrity: window counts invalid");
		if (CAL_CYC < 1 || PULSE_CYC < 1)
			$error("tli_link_integrity: counts must be positive");
	end

	//--------------------------------------------------------
	// Media selection and power-down
	//--------------------------------------------------------
	logic cable_meta_reg;
	logic cable_sync_reg;
	logic [CALW-1:0] cal_reg;

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			cable_meta_reg <= 1'b0;
			cable_sync_reg <= 1'b0;
		end
		else
		begin
			cable_meta_reg <= tp_cable_pin;
			cable_sync_reg <= cable_meta_reg;
		end
	end

	always_ff @(posedge clock)
	begin
		if (reset)
			tp_selected <= 1'b0;
		else
			tp_selected <= cable_sync_reg;
	end

	assign tp_power_down = !tp_selected;

	always_ff @(posedge clock)
	begin
		if (reset || !tp_selected)
			cal_reg <= '0;
		else if (cal_reg != CALW'(CAL_CYC))
			cal_reg <= cal_reg + 1'b1;
	end

	assign tp_ready = tp_selected && cal_reg == CALW'(CAL_CYC);

	//--------------------------------------------------------
	// Reception window
	//--------------------------------------------------------
	logic win_open;
	logic win_closed;
	logic pulse_ok;
	logic frame_seen;
	logic win_restart;
	logic armed_reg;
	tli_link_state_t state_reg;

	assign pulse_ok = link_check_en && rx_ev.link_pulse && win_open;
	assign frame_seen = rx_ev.frame_end || rx_ev.rx_active;
	assign win_restart = !tp_ready || pulse_ok || frame_seen;

	tli_timer #(
		.WIDTH(WW),
		.OPEN_CNT(WW'(WIN_OPEN_CYC)),
		.CLOSE_CNT(WW'(WIN_CLOSE_CYC))
	) u_window (
		.clock(clock),
		.reset(reset),
		.restart(win_restart),
		.past_open(win_open),
		.past_close(win_closed)
	);

	// tracks first in-window pulse after failure
	always_ff @(posedge clock)
	begin
		if (reset || state_reg != TLI_LINK_FAIL)
			armed_reg <= 1'b0;
		else if (frame_seen)
			armed_reg <= 1'b0;
		else if (pulse_ok)
			armed_reg <= 1'b1;
	end

	//--------------------------------------------------------
	// Link state machine
	//--------------------------------------------------------
	always_ff @(posedge clock)
	begin
		if (reset || !tp_ready)
			state_reg <= TLI_LINK_IDLE;
		else
		begin
			case (state_reg)
				TLI_LINK_IDLE:
				begin
					if (link_check_en && win_closed && !win_restart)
						state_reg <= TLI_LINK_FAIL;
				end
				TLI_LINK_FAIL:
				begin
					if ((pulse_ok && armed_reg) || rx_ev.frame_end)
						state_reg <= TLI_LINK_WAIT;
				end
				TLI_LINK_WAIT:
				begin
					if (!tx_active && !rx_ev.rx_active)
						state_reg <= TLI_LINK_IDLE;
				end
				default:
					state_reg <= TLI_LINK_IDLE;
			endcase
		end
	end

	assign link_state = state_reg;

	always_ff @(posedge clock)
	begin
		if (reset)
			func_en <= '0;
		else
		begin
			func_en.tx_enable <= tp_ready && state_reg == TLI_LINK_IDLE;
			func_en.rx_enable <= tp_ready && state_reg == TLI_LINK_IDLE;
			func_en.loopback_enable <= tp_ready &&
				state_reg == TLI_LINK_IDLE;
		end
	end

	//--------------------------------------------------------
	// Link pulse transmit
	//--------------------------------------------------------
	// periodic pulse, jabber and failure ignored
	tli_pulse_gen #(
		.PERIOD_CYC(LP_PERIOD_CYC),
		.WIDTH_CYC(PULSE_CYC)
	) u_pulse (
		.clock(clock),
		.reset(reset),
		.tx_busy(tx_active && state_reg == TLI_LINK_IDLE),
		.enable(tp_ready && link_check_en),
		.pulse_out(link_pulse_out),
		.pulse_sent()
	);

	//--------------------------------------------------------
	// Polarity detection and correction
	//--------------------------------------------------------
	logic [1:0] rev_idle_reg;
	logic [2:0] rev_link_reg;
	logic sense_on;

	assign sense_on = polarity_fix_en && !polarity_reversed && tp_ready;

	always_ff @(posedge clock)
	begin
		if (reset || !sense_on)
			rev_idle_reg <= '0;
		else if (rx_ev.frame_end)
			rev_idle_reg <= rx_ev.idle_reversed ?
				rev_idle_reg + 2'h1 : 2'h0;
	end

	always_ff @(posedge clock)
	begin
		if (reset || !sense_on)
			rev_link_reg <= '0;
		else if (link_check_en && rx_ev.link_pulse &&
			rx_ev.pulse_reversed)
			rev_link_reg <= rev_link_reg + 3'h1;
	end

	always_ff @(posedge clock)
	begin
		if (reset || !polarity_fix_en || !tp_selected)
			polarity_reversed <= 1'b0;
		else if (rev_idle_reg == 2'(`TLI_REV_IDLE_LIMIT) ||
			rev_link_reg == 3'(`TLI_REV_LINK_LIMIT))
			polarity_reversed <= 1'b1;
	end

	always_ff @(posedge clock)
	begin
		if (reset)
			rx_data <= 1'b0;
		else
			rx_data <= rx_data_raw ^ polarity_reversed;
	end

	//--------------------------------------------------------
	// Assertions
	//--------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	a_fail_disables: assert property (
		state_reg == TLI_LINK_FAIL |=> !func_en.tx_enable &&
		!func_en.rx_enable && !func_en.loopback_enable)
		else $error("functions enabled during link failure");

	a_wait_disables: assert property (
		state_reg == TLI_LINK_WAIT |=> !func_en.rx_enable)
		else $error("receive enabled in wait state");

	a_expiry_fails: assert property (
		state_reg == TLI_LINK_IDLE && tp_ready && link_check_en &&
		win_closed && !win_restart |=> state_reg == TLI_LINK_FAIL)
		else $error("window expiry did not fail link");

	a_frame_recovers: assert property (
		state_reg == TLI_LINK_FAIL && tp_ready && rx_ev.frame_end
		|=> state_reg == TLI_LINK_WAIT)
		else $error("packet did not recover link");

	a_wait_exit: assert property (
		state_reg == TLI_LINK_WAIT && tp_ready &&
		(tx_active || rx_ev.rx_active) |=> state_reg != TLI_LINK_IDLE)
		else $error("left wait while traffic present");

	a_early_ignored: assert property (
		state_reg == TLI_LINK_FAIL && rx_ev.link_pulse && !win_open &&
		!frame_seen && tp_ready |=> $stable(armed_reg))
		else $error("early pulse affected state");

	a_invert_data: assert property (
		$past(polarity_reversed) |-> rx_data == !$past(rx_data_raw))
		else $error("reversed data not inverted");

	a_power_down: assert property (
		!tp_selected |-> !tp_ready ##1 !func_en.tx_enable)
		else $error("unselected unit active");

	a_pulse_width: assert property (
		$rose(link_pulse_out) |-> link_pulse_out [*2])
		else $error("link pulse too short");

	c_fail: cover property (state_reg == TLI_LINK_FAIL);
	c_recover: cover property (state_reg == TLI_LINK_WAIT ##1
		state_reg == TLI_LINK_IDLE);
	c_reverse: cover property ($rose(polarity_reversed));
	c_pulse: cover property ($rose(link_pulse_out));

endmodule : tli_link_integrity

`default_nettype wire

// ==== bench/tli_peer.sv ====
// Remote pair transceiver model feeding receive events
`timescale 1ns/1ps
`default_nettype none

module tli_peer (
	input wire logic clock, // System clock
	output tli_pkg::tli_rx_ev_t rx_ev, // Receive events
	output logic rx_data_raw // Received pair data
);
	import tli_pkg::*;

	initial
	begin
		rx_ev = '0;
		rx_data_raw = 1'b0;
	end

	task automatic send_pulse(input logic rev);
		@(negedge clock);
		rx_ev.link_pulse = 1'b1;
		rx_ev.pulse_reversed = rev;
		@(negedge clock);
		rx_ev.link_pulse = 1'b0;
		// Qualifier no longer held: show the inverse
		rx_ev.pulse_reversed = ~rev;
	endtask : send_pulse

	// Short frame, then its closing idle pulse
	task automatic send_frame(input logic rev);
		@(negedge clock);
		rx_ev.rx_active = 1'b1;
		repeat (4)
		begin
			@(negedge clock);
			rx_data_raw = ~rx_data_raw;
		end
		rx_ev.rx_active = 1'b0;
		rx_ev.frame_end = 1'b1;
		rx_ev.idle_reversed = rev;
		@(negedge clock);
		rx_ev.frame_end = 1'b0;
		rx_ev.idle_reversed = ~rev;
	endtask : send_frame

	task automatic set_raw(input logic v);
		@(negedge clock);
		rx_data_raw = v;
	endtask : set_raw

endmodule : tli_peer
`default_nettype wire

// ==== bench/tli_link_integrity_bench.sv ====
// Self-checking bench for the link integrity block
`timescale 1ns/1ps
`default_nettype none

module tli_link_integrity_bench;
	import tli_pkg::*;

	localparam int WO = 20;
	localparam int WC = 100;
	localparam int LP = 30;
	localparam int CAL = 10;
	localparam int PW = 12;

	logic clock = 1'b0;
	logic reset;
	logic tx_active;
	logic polarity_fix_en;
	logic link_check_en;
	logic tp_cable_pin;
	tli_rx_ev_t rx_ev;
	logic rx_data_raw;
	tli_func_en_t func_en;
	tli_link_state_t link_state;
	logic rx_data;
	logic polarity_reversed;
	logic tp_selected;
	logic tp_power_down;
	logic tp_ready;
	logic link_pulse_out;
	int miscompares = 0;
	int cmp_count = 0;
	int n;
	int hi;

	always #4 clock = ~clock;

	tli_link_integrity #(.WIN_OPEN_CYC(WO), .WIN_CLOSE_CYC(WC),
		.LP_PERIOD_CYC(LP), .CAL_CYC(CAL), .PULSE_CYC(PW)) uut (
		.clock(clock), .reset(reset), .rx_ev(rx_ev),
		.rx_data_raw(rx_data_raw), .tx_active(tx_active),
		.polarity_fix_en(polarity_fix_en), .link_check_en(link_check_en),
		.tp_cable_pin(tp_cable_pin), .func_en(func_en),
		.link_state(link_state), .rx_data(rx_data),
		.polarity_reversed(polarity_reversed), .tp_selected(tp_selected),
		.tp_power_down(tp_power_down), .tp_ready(tp_ready),
		.link_pulse_out(link_pulse_out));

	tli_peer peer (.clock(clock), .rx_ev(rx_ev), .rx_data_raw(rx_data_raw));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic tick(input int k);
		repeat (k) @(negedge clock);
	endtask : tick

	task automatic check(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic final_report();
		$display("checks %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : final_report

	// Bounded wait; running out ends the run
	task automatic wait_state(input tli_link_state_t st, input int bound);
		n = 0;
		while (link_state !== st && n < bound)
		begin
			tick(1);
			n++;
		end
		check("link_state", link_state, st);
		if (link_state !== st)
			final_report();
	endtask : wait_state

	task automatic wait_pulse(input int bound);
		n = 0;
		while (link_pulse_out !== 1'b1 && n < bound)
		begin
			tick(1);
			n++;
		end
		check("link_pulse_out", link_pulse_out, 1);
		if (link_pulse_out !== 1'b1)
			final_report();
	endtask : wait_pulse

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_power_up();
		check("tp_power_down", tp_power_down, 1);
		tp_cable_pin = 1'b1;
		tick(3);
		check("tp_selected", tp_selected, 1);
		check("tp_power_down", tp_power_down, 0);
		tick(CAL - 1);
		check("tp_ready early", tp_ready, 0);
		tick(1);
		check("tp_ready", tp_ready, 1);
		tick(1);
		check("func_en", func_en, 3'h7);
		$display("test power_up done");
	endtask : t_power_up

	task automatic t_pulse_gen();
		wait_pulse(LP + PW + 4);
		hi = 0;
		while (link_pulse_out === 1'b1 && hi < 2 * PW)
		begin
			tick(1);
			hi++;
		end
		check("pulse width", hi, PW);
		wait_pulse(2 * LP);
		check("pulse period", hi + n, LP);
		$display("test pulse_gen done");
	endtask : t_pulse_gen

	task automatic t_fail();
		wait_state(TLI_LINK_FAIL, WC + 4);
		tick(2);
		check("func_en fail", func_en, 0);
		tx_active = 1'b1;
		tick(PW + 1);
		wait_pulse(LP + 2);
		$display("test fail done");
	endtask : t_fail

	task automatic t_recover();
		peer.send_pulse(1'b0);
		tick(5);
		peer.send_pulse(1'b0);
		tick(2);
		check("early pulse", link_state, TLI_LINK_FAIL);
		tick(WO);
		peer.send_pulse(1'b0);
		tick(2);
		check("recovery", link_state, TLI_LINK_WAIT);
		tick(5);
		check("wait held", link_state, TLI_LINK_WAIT);
		check("func_en wait", func_en, 0);
		tx_active = 1'b0;
		tick(3);
		check("idle", link_state, TLI_LINK_IDLE);
		check("func_en idle", func_en, 3'h7);
		$display("test recover done");
	endtask : t_recover

	task automatic t_keepalive();
		repeat (5)
		begin
			peer.send_pulse(1'b0);
			tick(WO + 10);
		end
		check("kept alive", link_state, TLI_LINK_IDLE);
		// One in-window pulse, then early ones that must not restart
		peer.send_pulse(1'b0);
		repeat (2)
		begin
			tick(3);
			peer.send_pulse(1'b0);
		end
		// A restart by an early pulse would push failure past this bound
		wait_state(TLI_LINK_FAIL, WC - 5);
		peer.send_frame(1'b0);
		wait_state(TLI_LINK_IDLE, 6);
		$display("test keepalive done");
	endtask : t_keepalive

	task automatic t_polarity();
		polarity_fix_en = 1'b1;
		peer.send_frame(1'b1);
		peer.send_frame(1'b0);
		peer.send_frame(1'b1);
		tick(2);
		check("polarity proper", polarity_reversed, 0);
		peer.send_frame(1'b1);
		tick(2);
		check("polarity idle", polarity_reversed, 1);
		peer.set_raw(1'b1);
		tick(2);
		check("rx_data", rx_data, 0);
		polarity_fix_en = 1'b0;
		tick(2);
		check("polarity off", polarity_reversed, 0);
		polarity_fix_en = 1'b1;
		tick(WO);
		repeat (3)
		begin
			peer.send_pulse(1'b1);
			tick(WO + 5);
		end
		check("polarity three", polarity_reversed, 0);
		peer.send_pulse(1'b1);
		tick(2);
		check("polarity link", polarity_reversed, 1);
		$display("test polarity done");
	endtask : t_polarity

	task automatic t_check_off();
		link_check_en = 1'b0;
		polarity_fix_en = 1'b0;
		tick(2);
		polarity_fix_en = 1'b1;
		// Link pulses do not count toward reversal without link check
		repeat (4)
		begin
			peer.send_pulse(1'b1);
			tick(WO + 5);
		end
		check("pulses unused", polarity_reversed, 0);
		tick(WC);
		check("no expiry", link_state, TLI_LINK_IDLE);
		check("no link pulse", link_pulse_out, 0);
		$display("test check_off done");
	endtask : t_check_off

	task automatic t_deselect();
		tp_cable_pin = 1'b0;
		tick(4);
		check("tp_selected off", tp_selected, 0);
		check("tp_power_down on", tp_power_down, 1);
		check("tp_ready off", tp_ready, 0);
		$display("test deselect done");
	endtask : t_deselect

	initial
	begin
		reset = 1'b1;
		tx_active = 1'b0;
		polarity_fix_en = 1'b0;
		link_check_en = 1'b1;
		tp_cable_pin = 1'b0;
		tick(16);
		reset = 1'b0;
		tick(2);
		t_power_up();
		t_pulse_gen();
		t_fail();
		t_recover();
		t_keepalive();
		t_polarity();
		t_check_off();
		t_deselect();
		final_report();
	end

endmodule : tli_link_integrity_bench
`default_nettype wire
